// File: emb_consts.svh
// register offsets, field positions and reset values of the memory block
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH
`define OFS_CFG     8'h00
`define OFS_CTRL    8'h04
`define OFS_STAT    8'h08
`define OFS_IRQ_ST  8'h0c
`define OFS_IRQ_MSK 8'h10
`define CFG_MODE    2:0
`define CFG_ENC     3
`define CFG_GEOM    6:4
`define CFG_BYP     12:8
`define CFG_BYP_OUT 13
`define BYP_WDATA   0
`define BYP_WADDR   1
`define BYP_WE      2
`define BYP_RE      3
`define BYP_RADDR   4
`define CFG_RST     32'h0000_0000
`define CTRL_ICE    0
`define CTRL_OCE    1
`define CTRL_ICLR   2
`define CTRL_OCLR   3
`define CTRL_RST    4'h3
`define ST_MATCH    0
`define ST_BUSY     1
`define ST_ADDR     12:8
`define EV_HIT      0
`define EV_MISS     1
`define EV_WDONE    2
`define EV_W        3
`define GEOM_MAX    3'h4
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`endif

// File: emb_pkg.sv
// types of the embedded memory and match block
package emb_pkg;
  typedef enum logic [2:0] {MODE_RW, MODE_IO, MODE_SP, MODE_ROM, MODE_CAM} mode_type;
  typedef enum logic [1:0] {CW_IDLE, CW_WORD, CW_MASK} cam_wr_type;
  typedef struct packed {
    logic        we;
    logic        re;
    logic [10:0] waddr;
    logic [10:0] raddr;
    logic [15:0] wdata;
  } mem_in_type;
  typedef struct packed {
    logic        req;
    logic [4:0]  addr;
    logic [31:0] word;
    logic        dc_en;
    logic [31:0] dc;
  } cam_wr_type_s_type;
endpackage : emb_pkg

// File: embedded_memory_block.sv
// embedded memory block: ram, rom and match memory behind an axi4-lite slave
`include "emb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module embedded_memory_block #(
  parameter logic [15:0] MEM_FILL = 16'h0000,
  parameter int          ENTRIES  = 32,
  parameter int          KEY_W    = 32
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic                        irq,
  input  wire logic                   glb_clr,
  input  wire logic                   in_clr,
  input  wire logic                   out_clr,
  input  wire logic                   in_ce,
  input  wire logic                   out_ce,
  input  wire emb_pkg::mem_in_type    mem_in,
  output logic [15:0]                 rd_data,
  input  wire emb_pkg::cam_wr_type_s_type cam_wr,
  output logic                        cam_busy,
  input  wire logic                   cam_search,
  input  wire logic [31:0]            cam_key,
  output logic                        match,
  output logic [4:0]                  match_addr
);
  import emb_pkg::*;

  logic [31:0]        cfg_r;
  logic [3:0]         ctrl_r;
  logic [`EV_W-1:0]   irq_st_r;
  logic [`EV_W-1:0]   irq_msk_r;
  logic [`EV_W-1:0]   ev;
  logic               aw_got_r;
  logic               w_got_r;
  logic [7:0]         aw_r;
  logic [31:0]        wd_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic               do_wr;
  mode_type           mode;
  logic [2:0]         geom;
  logic               wce;
  logic               rce;
  logic               oce;
  logic               wclr;
  logic               rclr;
  logic               oclr;
  mem_in_type         wq_r;
  mem_in_type         rq_r;
  mem_in_type         eff;
  logic [15:0]        mem [128];
  logic [15:0]        rd_comb;
  logic [15:0]        out_r;
  logic [KEY_W-1:0]   cam_word [ENTRIES];
  logic [KEY_W-1:0]   cam_care [ENTRIES];
  logic [ENTRIES-1:0] cam_vld_r;
  logic [ENTRIES-1:0] hits;
  logic [ENTRIES-1:0] hits_r;
  logic               half_r;
  logic               match_r;
  logic [4:0]         maddr_r;
  cam_wr_type         cw_r;
  cam_wr_type_s_type  cwq_r;

  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = a == `OFS_CFG || a == `OFS_CTRL || a == `OFS_STAT ||
             a == `OFS_IRQ_ST || a == `OFS_IRQ_MSK;
  endfunction : reg_ok

  function automatic logic [15:0] slice(input logic [15:0] w, input logic [10:0] a,
                                        input logic [2:0] g);
    slice = (w >> (a[3:0] & ((4'h1 << g) - 4'h1)) * (5'h10 >> g)) &
            ((16'h1 << (5'h10 >> g)) - 16'h1);
  endfunction : slice

  assign mode = mode_type'(cfg_r[`CFG_MODE]);
  assign geom = (cfg_r[`CFG_GEOM] > `GEOM_MAX) ? `GEOM_MAX : cfg_r[`CFG_GEOM];

  // axi4-lite write channel
  assign awready = !aw_got_r && !bvalid_r;
  assign wready  = !w_got_r && !bvalid_r;
  assign do_wr   = aw_got_r && w_got_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_r     <= 8'h00;
      wd_r     <= 32'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OK;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        aw_r     <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wd_r    <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= reg_ok(aw_r) ? `RESP_OK : `RESP_ERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r  <= `CFG_RST;
      ctrl_r <= `CTRL_RST;
    end
    else if (do_wr && aw_r == `OFS_CFG)
      cfg_r <= wd_r;
    else if (do_wr && aw_r == `OFS_CTRL)
      ctrl_r <= wd_r[3:0];
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_r  <= '0;
      irq_msk_r <= '0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~((do_wr && aw_r == `OFS_IRQ_ST) ? wd_r[`EV_W-1:0] : '0)) | ev;
      if (do_wr && aw_r == `OFS_IRQ_MSK)
        irq_msk_r <= wd_r[`EV_W-1:0];
    end
  end
  assign irq = |(irq_st_r & irq_msk_r);

  // axi4-lite read channel
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `RESP_OK;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= reg_ok(araddr) ? `RESP_OK : `RESP_ERR;
      unique case (araddr)
        `OFS_CFG:     rdata_r <= cfg_r;
        `OFS_CTRL:    rdata_r <= {28'h0, ctrl_r};
        `OFS_STAT:    rdata_r <= {19'h0, maddr_r, 6'h0, cam_busy, match_r};
        `OFS_IRQ_ST:  rdata_r <= {29'h0, irq_st_r};
        `OFS_IRQ_MSK: rdata_r <= {29'h0, irq_msk_r};
        default:      rdata_r <= 32'h0;
      endcase
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  // separate enables and clears per side
  assign wce  = in_ce && ctrl_r[`CTRL_ICE];
  assign oce  = out_ce && ctrl_r[`CTRL_OCE];
  assign wclr = in_clr || glb_clr || ctrl_r[`CTRL_ICLR];
  assign oclr = out_clr || glb_clr || ctrl_r[`CTRL_OCLR];
  // rw mode puts read strobe and address on the read side
  assign rce  = (mode == MODE_RW) ? oce : wce;
  // other modes keep them with the input registers
  assign rclr = (mode == MODE_RW) ? oclr : wclr;

  // strobes taken from the user side
  always_ff @(posedge aclk or posedge wclr)
  begin
    if (wclr)
      wq_r <= '0;
    else if (!aresetn)
      wq_r <= '0;
    else if (wce)
      wq_r <= mem_in;
  end

  always_ff @(posedge aclk or posedge rclr)
  begin
    if (rclr)
      rq_r <= '0;
    else if (!aresetn)
      rq_r <= '0;
    else if (rce)
      rq_r <= mem_in;
  end

  always_comb
  begin
    eff       = wq_r;
    eff.wdata = cfg_r[8 + `BYP_WDATA] ? mem_in.wdata : wq_r.wdata;
    eff.waddr = cfg_r[8 + `BYP_WADDR] ? mem_in.waddr : wq_r.waddr;
    eff.we    = cfg_r[8 + `BYP_WE] ? mem_in.we : wq_r.we;
    eff.re    = cfg_r[8 + `BYP_RE] ? mem_in.re : rq_r.re;
    eff.raddr = cfg_r[8 + `BYP_RADDR] ? mem_in.raddr : rq_r.raddr;
    // single port shares the write address
    if (mode == MODE_SP)
      eff.raddr = eff.waddr;
  end

  // geometry selects field width and word index
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 128; i++)
        mem[i] <= MEM_FILL;
    end
    else if (eff.we && mode != MODE_ROM && mode != MODE_CAM)
    begin
      for (int b = 0; b < 16; b++)
        if (4'(b >> (3'h4 - geom)) == (eff.waddr[3:0] & ((4'h1 << geom) - 4'h1)))
          mem[7'(eff.waddr >> geom)][b] <= eff.wdata[4'(b) & ((4'h1 << (3'h4 - geom)) - 4'h1)];
    end
  end

  // rom reads as a look-up table
  assign rd_comb = slice(mem[7'(eff.raddr >> geom)], eff.raddr, geom);

  always_ff @(posedge aclk or posedge oclr)
  begin
    if (oclr)
      out_r <= 16'h0;
    else if (!aresetn)
      out_r <= 16'h0;
    else if (oce && mode == MODE_CAM)
      // low half of the hit lines, then the high half only when CFG_ENC is clear
      out_r <= half_r ? hits_r[31:16] : (cam_search ? hits[15:0] : out_r);
    else if (oce && (eff.re || mode == MODE_ROM))
      out_r <= rd_comb;
  end
  assign rd_data = (cfg_r[`CFG_BYP_OUT] && mode != MODE_CAM) ? rd_comb : out_r;

  // entry write: word cycle, then optional mask cycle
  always_ff @(posedge aclk or posedge wclr)
  begin
    if (wclr)
    begin
      cw_r      <= CW_IDLE;
      cwq_r     <= '0;
      cam_vld_r <= '0;
    end
    else if (!aresetn)
    begin
      cw_r      <= CW_IDLE;
      cwq_r     <= '0;
      cam_vld_r <= '0;
    end
    else
    begin
      unique case (cw_r)
        CW_IDLE:
          if (cam_wr.req && mode == MODE_CAM)
          begin
            cwq_r <= cam_wr;
            cw_r  <= CW_WORD;
          end
        CW_WORD:
        begin
          cam_word[cwq_r.addr] <= cwq_r.word;
          cam_care[cwq_r.addr] <= '1;
          cam_vld_r[cwq_r.addr] <= 1'b1;
          cw_r <= cwq_r.dc_en ? CW_MASK : CW_IDLE;
        end
        CW_MASK:
        begin
          cam_care[cwq_r.addr] <= ~cwq_r.dc;
          cw_r <= CW_IDLE;
        end
      endcase
    end
  end
  assign cam_busy = cw_r != CW_IDLE;

  // masked bits block a hit only while the mask cycle of their entry write is running
  generate
    for (genvar e = 0; e < ENTRIES; e++)
    begin : g_cmp
      assign hits[e] = cam_vld_r[e] && (((cam_word[e] ^ cam_key) & cam_care[e]) == '0);
    end
  endgenerate

  always_ff @(posedge aclk or posedge oclr)
  begin
    if (oclr)
    begin
      hits_r  <= '0;
      half_r  <= 1'b0;
      match_r <= 1'b0;
      maddr_r <= 5'h0;
    end
    else if (!aresetn)
    begin
      hits_r  <= '0;
      half_r  <= 1'b0;
      match_r <= 1'b0;
      maddr_r <= 5'h0;
    end
    else if (oce)
    begin
      half_r <= cam_search && mode == MODE_CAM && !cfg_r[`CFG_ENC];
      if (cam_search && mode == MODE_CAM)
      begin
        hits_r  <= hits;
        match_r <= |hits;
        maddr_r <= 5'h0;
        for (int e = ENTRIES - 1; e >= 0; e--)
          if (hits[e])
            maddr_r <= 5'(e);
      end
    end
  end
  assign match      = match_r;
  assign match_addr = match_r ? maddr_r : 5'h0;

  assign ev[`EV_HIT]   = oce && cam_search && mode == MODE_CAM && |hits;
  assign ev[`EV_MISS]  = oce && cam_search && mode == MODE_CAM && !(|hits);
  assign ev[`EV_WDONE] = cw_r != CW_IDLE && !(cw_r == CW_WORD && cwq_r.dc_en);
endmodule : embedded_memory_block
`default_nettype wire

// File: emb_chk.sv
// port checker of the embedded memory block
`timescale 1ns/1ps
`default_nettype none
module emb_chk (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [31:0]                rdata,
  input wire logic                       rvalid,
  input wire logic                       rready,
  input wire logic                       glb_clr,
  input wire logic                       out_clr,
  input wire emb_pkg::cam_wr_type_s_type cam_wr,
  input wire logic                       cam_busy,
  input wire logic                       match,
  input wire logic [4:0]                 match_addr
);
  import emb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence short_s;
    cam_busy ##1 !cam_busy;
  endsequence
  sequence long_s;
    cam_busy [*2] ##1 !cam_busy;
  endsequence
  sequence take_s;
    awvalid && awready && wvalid && wready;
  endsequence
  a_entry_plain: assert property (
    $rose(cam_busy) && !$past(cam_wr.dc_en) |-> short_s) else $error("entry write length");
  a_entry_mask: assert property (
    $rose(cam_busy) && $past(cam_wr.dc_en) |-> long_s) else $error("masked write length");
  a_nohit_addr: assert property (
    !match |-> match_addr == 5'h00) else $error("address without hit");
  a_clear_out: assert property (
    (out_clr || glb_clr) [*2] |-> !match) else $error("clear ignored");
  a_write_resp: assert property (
    take_s |-> ##2 bvalid) else $error("write response late");
  a_resp_hold: assert property (
    bvalid && !bready |=> bvalid) else $error("write response dropped");
  a_read_next: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("read answer late");
  a_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
  a_bus_block: assert property (
    bvalid |-> !awready && !wready) else $error("write taken while busy");
endmodule : emb_chk
`default_nettype wire

// File: user_logic_model.sv
// neighbouring user logic driving the match memory
`timescale 1ns/1ps
`default_nettype none
module user_logic_model (
  input wire logic                   aclk,
  input wire logic                   cam_busy,
  output var emb_pkg::cam_wr_type_s_type cam_wr,
  output logic                       cam_search,
  output logic [31:0]                cam_key
);
  import emb_pkg::*;
  initial
  begin
    cam_wr = '0;
    {cam_search, cam_key} = '0;
  end
  task automatic put(input logic [4:0] a, input logic [31:0] w, input logic de,
                     input logic [31:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'h0;
    cam_wr <= '{1'h1, a, w, de, d};
    @(posedge aclk);
    cam_wr <= '{1'h0, ~a, ~w, ~de, ~d};
    while (!ok && n < 8)
    begin
      @(negedge aclk);
      ok = !cam_busy;
      n++;
    end
    @(posedge aclk);
  endtask : put
  task automatic find(input logic [31:0] k);
    cam_search <= 1'h1;
    cam_key <= k;
    @(posedge aclk);
    cam_search <= 1'h0;
    cam_key <= ~k;
  endtask : find
endmodule : user_logic_model
`default_nettype wire

// File: embedded_memory_block_tb.sv
// self-checking bench of the embedded memory block
`include "emb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module embedded_memory_block_tb;
  import emb_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic arready, rvalid, rready, irq, glb_clr, in_clr, out_clr, in_ce, out_ce;
  logic cam_busy, cam_search, match, ok, pa, pw, pr, sv, ta, tw;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [4:0]  match_addr;
  logic [7:0]  awaddr, araddr;
  logic [10:0] a;
  logic [15:0] rd_data, d, p, mk, mm[128];
  logic [31:0] wdata, rdata, cam_key, v, mv, mw[32], md[32];
  logic [31:0] kq[$];
  mem_in_type  mem_in;
  cam_wr_type_s_type cam_wr;
  int errors, cmp_count, n, sh;
  embedded_memory_block #(.MEM_FILL(16'h5a3c)) embedded_memory_block_inst (.*);
  user_logic_model user_logic_model_inst (.*);
  always #25 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    {pa, pw, pr, n} = {3'h7, 32'h0};
    awaddr <= ad;
    wdata <= dt;
    {awvalid, wvalid} <= 2'h3;
    while (pr && n < 40)
    begin
      @(negedge aclk);
      n++;
      if (bready && bvalid)
      begin
        chk("bresp", er, bresp);
        pr = 1'h0;
      end
      {ta, tw, sv} = {pa && awready, pw && wready, bvalid && !bready};
      {pa, pw} = {pa && !ta, pw && !tw};
      @(posedge aclk);
      if (ta || tw)
        {awvalid, wvalid} <= {pa, pw};
      if (sv || !pr)
        bready <= pr;
    end
    if (pr)
    begin
      errors++;
      finish_test;
    end
  endtask : axw
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    {pa, pr, n} = {2'h3, 32'h0};
    araddr <= ad;
    arvalid <= 1'h1;
    while (pr && n < 40)
    begin
      @(negedge aclk);
      n++;
      if (rready && rvalid)
      begin
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
        pr = 1'h0;
      end
      {ta, sv} = {pa && arready, rvalid && !rready};
      pa = pa && !ta;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'h0;
      if (sv || !pr)
        rready <= pr;
    end
    if (pr)
    begin
      errors++;
      finish_test;
    end
  endtask : rchk
  task automatic look(input logic [31:0] k, input logic enc);
    logic [31:0] h;
    logic [4:0]  e;
    e = 5'h00;
    for (int i = 0; i < 32; i++)
      h[i] = mv[i] && ((mw[i] ^ k) & ~md[i]) == 32'h0;
    for (int i = 31; i >= 0; i--)
      if (h[i]) e = 5'(i);
    user_logic_model_inst.find(k);
    @(negedge aclk);
    chk("match", |h, match);
    chk("match_addr", e, match_addr);
    chk("hits_lo", h[15:0], rd_data);
    @(negedge aclk);
    if (!enc) chk("hits_hi", h[31:16], rd_data);
    @(posedge aclk);
  endtask : look
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, glb_clr, in_clr} = '0;
    {out_clr, in_ce, out_ce, wstrb, awaddr, araddr, wdata, mv} = {3'h3, 4'hf, 80'h0};
    mem_in = '0;
    foreach (mm[i]) mm[i] = 16'h5a3c;
    v = $urandom(32'hdbee);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(`OFS_CFG, 32'h0, 2'h0);
    rchk(`OFS_CTRL, 32'h3, 2'h0);
    rchk(8'h14, 32'h0, 2'h2);
    axw(8'h14, 32'hffff_ffff, 2'h2);
    $display("test registers done");
    axw(`OFS_IRQ_MSK, 32'h0, 2'h0);
    axw(`OFS_CFG, 32'hc, 2'h0);
    for (int i = 0; i < 32; i = i * 2 + 1)
    begin
      {mw[i], md[i], mv[i]} = {$urandom, (i == 7) ? 32'h0000_ff00 : 32'h0, 1'h1};
      user_logic_model_inst.put(5'(i), mw[i], i == 7, md[i], ok);
      chk("entry_ok", 1'h1, ok);
      if (!ok) finish_test;
    end
    kq = '{mw[31], mw[7] ^ 32'h0000_5a00, ~mw[0], mw[0]};
    foreach (kq[j]) look(kq[j], 1'h1);
    rchk(`OFS_IRQ_ST, 32'h7, 2'h0);
    chk("irq", 1'h0, irq);
    axw(`OFS_IRQ_MSK, 32'h1, 2'h0);
    chk("irq", 1'h1, irq);
    axw(`OFS_IRQ_ST, 32'h1, 2'h0);
    rchk(`OFS_IRQ_ST, 32'h6, 2'h0);
    chk("irq", 1'h0, irq);
    $display("test match encoded done");
    axw(`OFS_CFG, 32'h4, 2'h0);
    {mw[20], md[20], mv[20]} = {mw[3], 32'h0, 1'h1};
    user_logic_model_inst.put(5'd20, mw[20], 1'h0, 32'h0, ok);
    look(mw[3], 1'h0);
    out_clr <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("match", 1'h0, match);
    @(posedge aclk);
    out_clr <= 1'h0;
    $display("test match unencoded done");
    for (int m = 0; m < 3; m++)
      for (int g = 0; g < 5; g++)
      begin
        axw(`OFS_CFG, 32'(m + g * 16), 2'h0);
        a = 11'($urandom_range((128 << g) - 1));
        d = 16'($urandom);
        mk = 16'((17'h1 << (16 >> g)) - 1);
        p = d & mk;
        sh = (int'(a) & ((1 << g) - 1)) * (16 >> g);
        mm[a >> g] = (mm[a >> g] & ~(mk << sh)) | (p << sh);
        mem_in <= '{1'h1, 1'h0, a, a + 11'h1, d};
        @(posedge aclk);
        mem_in <= '{1'h0, 1'h1, a, (m == 2) ? ~a : a, ~d};
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("rd_data", p, rd_data);
        @(posedge aclk);
        mem_in <= '{1'h0, 1'h0, ~a, ~a, ~d};
      end
    $display("test ram done");
    out_ce <= 1'h0;
    axw(`OFS_CFG, 32'h3, 2'h0);
    a = 11'($urandom_range(127));
    mem_in <= '{1'h0, 1'h1, a, a, 16'h0};
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("rd_data", p, rd_data);
    @(posedge aclk);
    out_ce <= 1'h1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("rd_data", mm[a], rd_data);
    @(posedge aclk);
    {glb_clr, in_clr} <= 2'h3;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("rd_data", 16'h0, rd_data);
    @(posedge aclk);
    {glb_clr, in_clr} <= 2'h0;
    $display("test rom done");
    finish_test;
  end
endmodule : embedded_memory_block_tb
bind embedded_memory_block emb_chk emb_chk_inst (.*);
`default_nettype wire
